// ===== src/cmpc_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "cmpc_regs.svh"

module cmpc_top (
    input  wire logic               clk,
    input  wire logic               rstn,
    input  wire logic               ce,
    input  wire cmpc_pkg::cmpc_addr_t reg_addr,
    input  wire cmpc_pkg::cmpc_data_t reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output logic [7:0]              reg_rdata,
    input  wire logic [3:0]         cmp_raw_result,
    input  wire logic               io_clock_tick,
    input  wire logic               pll_tick,
    input  wire logic [2:0]         amp_tick,
    output logic [3:0]              cmp_enable,
    output logic [3:0]              cmp_clock_source_bit,
    output logic [11:0]             negative_input_mux,
    output logic [2:0]              amp_route_bit,
    output logic [3:0]              cmp_output_state,
    output logic [3:0]              cmp_irq,
    output logic [3:0]              conv_trigger,
    output logic                    tmr1_capture_src,
    output logic                    irq
);
    import cmpc_pkg::*;

    // register state
    cmpc_ctrl_t ctrl_q [`CMPC_NUM];
    cmpc_ctrl_t ctrl_d [`CMPC_NUM];
    logic [3:0] mask_q;
    logic [3:0] mask_d;
    logic [2:0] route_q;
    logic [2:0] route_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic [3:0] clr_w;

    // synchroniser state
    logic [3:0] sync1_q;
    logic [3:0] sync2_q;

    // per-comparator state
    logic       sample_q [`CMPC_NUM];
    logic       sample_d [`CMPC_NUM];
    logic       flag_q   [`CMPC_NUM];
    logic       flag_d   [`CMPC_NUM];
    logic       tick_w   [`CMPC_NUM];
    logic       ev_w     [`CMPC_NUM];
    logic       en_w     [`CMPC_NUM];
    logic       ie_w     [`CMPC_NUM];
    logic       amp_sel_w[`CMPC_NUM];
    logic       amp_tk_w [`CMPC_NUM];
    cmpc_sense_t sense_w [`CMPC_NUM];
    logic [3:0] flag_vec;
    logic [3:0] out_vec;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    // two-stage synchroniser for the analog results
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sync1_q <= 4'h0;
            sync2_q <= 4'h0;
        end else if (ce) begin
            sync1_q <= cmp_raw_result;
            sync2_q <= sync1_q;
        end
    end

    // register writes, flag clears and read data
    always_comb begin
        for (int k = 0; k < `CMPC_NUM; k++) begin
            ctrl_d[k] = ctrl_q[k];
        end
        mask_d  = mask_q;
        route_d = route_q;
        clr_w   = 4'h0;
        rdata_d = 8'h00;
        if (reg_wr) begin
            unique case (reg_addr)
                `CMPC_ADDR_CTRL0: ctrl_d[0] = reg_wdata;
                `CMPC_ADDR_CTRL1: ctrl_d[1] = reg_wdata;
                `CMPC_ADDR_CTRL2: ctrl_d[2] = reg_wdata;
                `CMPC_ADDR_CTRL3: ctrl_d[3] = reg_wdata;
                `CMPC_ADDR_STAT:  clr_w = reg_wdata[`CMPC_FLAG_HI:`CMPC_FLAG_LO];
                `CMPC_ADDR_MASK:  mask_d = reg_wdata[`CMPC_FLAG_HI:`CMPC_FLAG_LO];
                `CMPC_ADDR_ROUTE: route_d = reg_wdata[2:0];
                default: ;
            endcase
        end
        if (reg_rd) begin
            unique case (reg_addr)
                `CMPC_ADDR_CTRL0: rdata_d = ctrl_q[0];
                `CMPC_ADDR_CTRL1: rdata_d = ctrl_q[1];
                `CMPC_ADDR_CTRL2: rdata_d = ctrl_q[2];
                `CMPC_ADDR_CTRL3: rdata_d = ctrl_q[3];
                `CMPC_ADDR_STAT:  rdata_d = {flag_vec, out_vec};
                `CMPC_ADDR_MASK:  rdata_d = {mask_q, 4'h0};
                `CMPC_ADDR_ROUTE: rdata_d = {5'h00, route_q};
                default:          rdata_d = 8'h00;
            endcase
        end
    end

    // register file flops
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            for (int k = 0; k < `CMPC_NUM; k++) begin
                ctrl_q[k] <= `CMPC_CTRL_RST;
            end
            mask_q  <= `CMPC_MASK_RST;
            route_q <= `CMPC_ROUTE_RST;
            rdata_q <= 8'h00;
        end else if (ce) begin
            for (int k = 0; k < `CMPC_NUM; k++) begin
                ctrl_q[k] <= ctrl_d[k];
            end
            mask_q  <= mask_d;
            route_q <= route_d;
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata        = rdata_q;
    assign amp_route_bit    = route_q;
    assign tmr1_capture_src = sample_q[1];
    assign conv_trigger     = flag_vec;
    assign irq              = |(cmp_irq & mask_q);

    // one slice per comparator
    for (genvar i = 0; i < `CMPC_NUM; i++) begin : g_cmp

        // control field decode
        assign en_w[i]    = ctrl_q[i][`CMPC_BIT_EN];
        assign ie_w[i]    = ctrl_q[i][`CMPC_BIT_IE];
        assign sense_w[i] = cmpc_sense_t'(ctrl_q[i][`CMPC_SENSE_HI:`CMPC_SENSE_LO]);

        // amplifier routing exists on the first three only
        if (i < `CMPC_NAMP) begin : g_amp
            assign amp_sel_w[i] = route_q[i];
            assign amp_tk_w[i]  = amp_tick[i];
        end else begin : g_noamp
            assign amp_sel_w[i] = 1'b0;
            assign amp_tk_w[i]  = 1'b0;
        end

        // comparator clock choice
        assign tick_w[i] = amp_sel_w[i] ? amp_tk_w[i] :
                           (ctrl_q[i][`CMPC_BIT_CKSEL] ? pll_tick
                                                        : io_clock_tick);

        // analog-side drives
        assign cmp_enable[i]           = en_w[i];
        assign cmp_clock_source_bit[i] = ctrl_q[i][`CMPC_BIT_CKSEL];
        assign negative_input_mux[i*`CMPC_NEG_W +: `CMPC_NEG_W] =
            ctrl_q[i][`CMPC_NEG_HI:`CMPC_NEG_LO];

        // sampling and event detection
        always_comb begin
            ev_w[i] = 1'b0;
            unique case (sense_w[i])
                CMPC_SENSE_TOGGLE: ev_w[i] = sync2_q[i] ^ sample_q[i];
                CMPC_SENSE_RSVD:   ev_w[i] = 1'b0;
                CMPC_SENSE_FALL:   ev_w[i] = sample_q[i] & ~sync2_q[i];
                CMPC_SENSE_RISE:   ev_w[i] = ~sample_q[i] & sync2_q[i];
            endcase
            ev_w[i] = ev_w[i] & en_w[i] & tick_w[i];
            if (!en_w[i]) begin
                sample_d[i] = 1'b0;
            end else if (tick_w[i]) begin
                sample_d[i] = sync2_q[i];
            end else begin
                sample_d[i] = sample_q[i];
            end
            flag_d[i] = ev_w[i] | (flag_q[i] & ~clr_w[i]);
        end

        // comparator slice flops
        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
                sample_q[i] <= 1'b0;
                flag_q[i]   <= 1'b0;
            end else if (ce) begin
                sample_q[i] <= sample_d[i];
                flag_q[i]   <= flag_d[i];
            end
        end

        assign out_vec[i]          = sample_q[i];
        assign cmp_output_state[i] = sample_q[i];
        assign flag_vec[i]         = flag_q[i];
        assign cmp_irq[i]          = flag_q[i] & ie_w[i];

        // steady raw level reaches the output after sync and one tick
        sequence s_steady;
            (cmp_raw_result[i] && en_w[i] && tick_w[i] && ce)[*3];
        endsequence
        sequence s_cleared;
            ce && flag_q[i] && clr_w[i] && !ev_w[i];
        endsequence

        property p_steady_out;
            s_steady |-> ##1 sample_q[i];
        endproperty
        a_steady_out: assert property (p_steady_out)
            else $error("output did not follow steady comparator result");

        property p_disabled_low;
            (ce && !en_w[i]) |=> !sample_q[i] && !cmp_output_state[i];
        endproperty
        a_disabled_low: assert property (p_disabled_low)
            else $error("disabled comparator output not low");

        property p_rise_sets;
            (ce && en_w[i] && tick_w[i] && sense_w[i] == CMPC_SENSE_RISE
             && !sample_q[i] && sync2_q[i]) |=> flag_q[i] && conv_trigger[i];
        endproperty
        a_rise_sets: assert property (p_rise_sets)
            else $error("rising edge did not set flag");

        property p_fall_sets;
            (ce && en_w[i] && tick_w[i] && sense_w[i] == CMPC_SENSE_FALL
             && sample_q[i] && !sync2_q[i]) |=> flag_q[i];
        endproperty
        a_fall_sets: assert property (p_fall_sets)
            else $error("falling edge did not set flag");

        property p_rsvd_quiet;
            (sense_w[i] == CMPC_SENSE_RSVD && !flag_q[i]) |=> !flag_q[i];
        endproperty
        a_rsvd_quiet: assert property (p_rsvd_quiet)
            else $error("reserved sense code raised a flag");

        property p_flag_holds;
            (flag_q[i] && !clr_w[i]) |=> flag_q[i];
        endproperty
        a_flag_holds: assert property (p_flag_holds)
            else $error("flag dropped without a clear");

        property p_flag_clears;
            s_cleared |=> !flag_q[i] && !cmp_irq[i];
        endproperty
        a_flag_clears: assert property (p_flag_clears)
            else $error("write of one did not clear flag");

        property p_set_wins;
            (ce && ev_w[i] && clr_w[i]) |=> flag_q[i];
        endproperty
        a_set_wins: assert property (p_set_wins)
            else $error("event lost against a clear");

        property p_irq_gate;
            !ie_w[i] |-> !cmp_irq[i];
        endproperty
        a_irq_gate: assert property (p_irq_gate)
            else $error("interrupt raised while disabled");

        property p_clock_hold;
            (ce && en_w[i] && !tick_w[i]) |=> $stable(sample_q[i]);
        endproperty
        a_clock_hold: assert property (p_clock_hold)
            else $error("output moved without a comparator clock");

        property p_amp_clock;
            (ce && en_w[i] && amp_sel_w[i] && !amp_tk_w[i]
             && pll_tick && io_clock_tick) |=> $stable(sample_q[i]);
        endproperty
        a_amp_clock: assert property (p_amp_clock)
            else $error("routed comparator sampled off amplifier clock");

        property p_toggle_sets;
            (ce && en_w[i] && tick_w[i] && sense_w[i] == CMPC_SENSE_TOGGLE
             && (sample_q[i] != sync2_q[i])) |=> flag_q[i];
        endproperty
        a_toggle_sets: assert property (p_toggle_sets)
            else $error("toggle did not set flag");

        property p_flag_source;
            (ce && !flag_q[i] && !ev_w[i]) |=> !flag_q[i];
        endproperty
        a_flag_source: assert property (p_flag_source)
            else $error("flag set without a selected event");

        property p_pll_clock;
            (ce && en_w[i] && !amp_sel_w[i] && ctrl_q[i][`CMPC_BIT_CKSEL]
             && !pll_tick && io_clock_tick) |=> $stable(sample_q[i]);
        endproperty
        a_pll_clock: assert property (p_pll_clock)
            else $error("comparator sampled off the selected clock");

        property p_io_clock;
            (ce && en_w[i] && !amp_sel_w[i] && !ctrl_q[i][`CMPC_BIT_CKSEL]
             && io_clock_tick) |=> sample_q[i] == $past(sync2_q[i]);
        endproperty
        a_io_clock: assert property (p_io_clock)
            else $error("comparator missed an io clock tick");

        property p_ctrl_write;
            (ce && reg_wr && reg_addr == cmpc_addr_t'(i))
                |=> ctrl_q[i] == $past(reg_wdata)
                    && cmp_enable[i] == $past(reg_wdata[`CMPC_BIT_EN]);
        endproperty
        a_ctrl_write: assert property (p_ctrl_write)
            else $error("control write not applied");
    end

    // status read returns outputs and flags one cycle later
    property p_stat_read;
        (ce && reg_rd && reg_addr == `CMPC_ADDR_STAT)
            |=> reg_rdata == {$past(flag_vec), $past(out_vec)};
    endproperty
    a_stat_read: assert property (p_stat_read)
        else $error("shared status read mismatch");

    property p_capture_src;
        ##1 tmr1_capture_src == cmp_output_state[1];
    endproperty
    a_capture_src: assert property (p_capture_src)
        else $error("capture source differs from comparator 1");

    // route register write reaches the amplifier switches
    property p_route_write;
        (ce && reg_wr && reg_addr == `CMPC_ADDR_ROUTE)
            |=> amp_route_bit == $past(reg_wdata[2:0]);
    endproperty
    a_route_write: assert property (p_route_write)
        else $error("route write not applied");

    // read data stands only after a read strobe
    property p_rdata_idle;
        (ce && !reg_rd) |=> reg_rdata == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data without a read");

    // a fully masked block keeps the shared request low
    property p_mask_gate;
        (mask_q == 4'h0) |-> !irq;
    endproperty
    a_mask_gate: assert property (p_mask_gate)
        else $error("masked request reached irq");

endmodule
`default_nettype wire

// ===== src/cmpc_regs.svh
`ifndef CMPC_REGS_SVH
`define CMPC_REGS_SVH

`define CMPC_NUM         4
`define CMPC_NAMP        3
`define CMPC_NEG_W       3

`define CMPC_ADDR_CTRL0  3'h0
`define CMPC_ADDR_CTRL1  3'h1
`define CMPC_ADDR_CTRL2  3'h2
`define CMPC_ADDR_CTRL3  3'h3
`define CMPC_ADDR_STAT   3'h4
`define CMPC_ADDR_MASK   3'h5
`define CMPC_ADDR_ROUTE  3'h6

`define CMPC_BIT_EN      7
`define CMPC_BIT_IE      6
`define CMPC_SENSE_HI    5
`define CMPC_SENSE_LO    4
`define CMPC_BIT_CKSEL   3
`define CMPC_NEG_HI      2
`define CMPC_NEG_LO      0

`define CMPC_FLAG_HI     7
`define CMPC_FLAG_LO     4

`define CMPC_CTRL_RST    8'h00
`define CMPC_MASK_RST    4'h0
`define CMPC_ROUTE_RST   3'h0

`endif

// ===== src/cmpc_pkg.sv
package cmpc_pkg;

    // interrupt sensitivity codes
    typedef enum logic [1:0] {
        CMPC_SENSE_TOGGLE = 2'h0,
        CMPC_SENSE_RSVD   = 2'h1,
        CMPC_SENSE_FALL   = 2'h2,
        CMPC_SENSE_RISE   = 2'h3
    } cmpc_sense_t;

    typedef logic [7:0] cmpc_data_t;
    typedef logic [2:0] cmpc_addr_t;
    typedef logic [7:0] cmpc_ctrl_t;

endpackage

// ===== verif/cmpc_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
module cmpc_top_bench;
    import cmpc_pkg::*;
    logic        clk;
    logic        rstn;
    logic        ce;
    cmpc_addr_t  reg_addr;
    cmpc_data_t  reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  reg_rdata;
    logic [3:0]  raw;
    logic        io_tick;
    logic        pll_tick;
    logic [2:0]  amp_tick;
    logic [3:0]  cmp_en;
    logic [3:0]  cksel;
    logic [11:0] neg_mux;
    logic [2:0]  route;
    logic [3:0]  outs;
    logic [3:0]  cmp_irq;
    logic [3:0]  conv_trig;
    logic        tmr1_src;
    logic        irq;
    int          n_mismatch;
    int          checks_done;
    int          seed;
    int          c;
    int          k;
    logic [7:0]  v;
    logic [7:0]  rv;
    logic [1:0]  sense;
    logic        ie;

    cmpc_top uut (.clk(clk), .rstn(rstn), .ce(ce), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .cmp_raw_result(raw), .io_clock_tick(io_tick), .pll_tick(pll_tick),
        .amp_tick(amp_tick), .cmp_enable(cmp_en), .cmp_clock_source_bit(cksel),
        .negative_input_mux(neg_mux), .amp_route_bit(route), .cmp_output_state(outs),
        .cmp_irq(cmp_irq), .conv_trigger(conv_trig), .tmr1_capture_src(tmr1_src),
        .irq(irq));

    // clock, 5 ns period
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // expected event for a sense code and edge direction
    function automatic logic exp_evt(logic [1:0] s, logic up);
        return (s == CMPC_SENSE_TOGGLE) || (up ? s == CMPC_SENSE_RISE : s == CMPC_SENSE_FALL);
    endfunction

    task automatic chk(string n, logic [11:0] e, logic [11:0] g);
        checks_done++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic wr(logic [2:0] a, logic [7:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr    <= 1'b0;
        #1;
    endtask

    task automatic rd(logic [2:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task automatic wait_cyc(int n);
        repeat (n) @(posedge clk);
    endtask

    // status, outputs and request lines of one comparator
    task automatic chk_state(int k, logic o, logic f, logic e);
        logic [7:0] es;
        logic [7:0] s;
        es = 8'h00;
        es[k + 4] = f;
        es[k] = o;
        rd(3'h4, s);
        chk("stat", 12'(es), 12'(s));
        chk("out", 12'(o), 12'(outs[k]));
        chk("trig", 12'(f), 12'(conv_trig[k]));
        chk("cirq", 12'(f & e), 12'(cmp_irq[k]));
        chk("irq", 12'(f & e), 12'(irq));
        chk("tmr1", 12'((k == 1) & o), 12'(tmr1_src));
    endtask

    task automatic complete_run();
        if (n_mismatch == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // watchdog
    initial begin
        wait_cyc(20000);
        n_mismatch++;
        complete_run();
    end

    // main sequence
    initial begin
        rstn = 1'b0; ce = 1'b1; reg_addr = '0; reg_wdata = '0; reg_wr = 1'b0;
        reg_rd = 1'b0; raw = 4'h0; io_tick = 1'b1; pll_tick = 1'b0; amp_tick = 3'h0;
        n_mismatch = 0; checks_done = 0; seed = 32'hcd64b1d1;
        wait_cyc(12);
        rstn <= 1'b1;
        for (int a = 0; a < 8; a++) begin
            rd(3'(a), rv);
            chk("rst", 12'h0, 12'(rv));
        end
        // random control values read back and reach the analog side
        for (int i = 0; i < 8; i++) begin
            c = i % 4;
            v = 8'($random(seed));
            wr(3'(c), v);
            rd(3'(c), rv);
            chk("ctrl", 12'(v), 12'(rv));
            chk("en", 12'(v[7]), 12'(cmp_en[c]));
            chk("cksel", 12'(v[3]), 12'(cksel[c]));
            chk("neg", 12'(v[2:0]), 12'(neg_mux[3*c +: 3]));
            wr(3'(c), 8'h00);
        end
        v = 8'($random(seed));
        wr(3'h6, v);
        rd(3'h6, rv);
        chk("route", 12'(v[2:0]), 12'(rv));
        chk("routeb", 12'(v[2:0]), 12'(route));
        wr(3'h6, 8'h00);
        wr(3'h7, 8'hff);
        rd(3'h7, rv);
        chk("unmap", 12'h0, 12'(rv));
        wr(3'h5, 8'hff);
        rd(3'h5, rv);
        chk("mask", 12'hf0, 12'(rv));
        // write lost while clock enable is low
        @(posedge clk) ce <= 1'b0;
        wr(3'h0, 8'h80);
        @(posedge clk) ce <= 1'b1;
        rd(3'h0, rv);
        chk("ce", 12'h0, 12'(rv));
        // every sense code, one comparator each
        for (k = 0; k < 4; k++) begin
            sense = 2'(k);
            ie = 1'($random(seed));
            wr(3'h5, 8'hf0);
            wr(3'h4, 8'hf0);
            wr(3'(k), {1'b1, ie, sense, 4'h0});
            @(posedge clk) raw[k] <= 1'b1;
            wait_cyc(6);
            chk_state(k, 1'b1, exp_evt(sense, 1'b1), ie);
            wr(3'h5, 8'h00);
            chk("masked", 12'h0, 12'(irq));
            chk("unmask", 12'(exp_evt(sense, 1'b1) & ie), 12'(cmp_irq[k]));
            wr(3'h5, 8'hf0);
            wait_cyc(3);
            chk_state(k, 1'b1, exp_evt(sense, 1'b1), ie);
            wr(3'h4, 8'(8'h10 << k));
            chk_state(k, 1'b1, 1'b0, ie);
            @(posedge clk) raw[k] <= 1'b0;
            wait_cyc(6);
            chk_state(k, 1'b0, exp_evt(sense, 1'b0), ie);
            wr(3'h4, 8'hf0);
            wr(3'(k), 8'h00);
            @(posedge clk) raw[k] <= 1'b1;
            wait_cyc(6);
            chk("dis", 12'h0, 12'(outs[k]));
            @(posedge clk) raw[k] <= 1'b0;
        end
        // clear and rising event in one cycle: the event wins
        wr(3'h4, 8'hf0);
        wr(3'h3, 8'hf8);
        @(posedge clk) raw[3] <= 1'b1;
        wait_cyc(4);
        @(posedge clk) begin
            pll_tick  <= 1'b1;
            reg_wr    <= 1'b1;
            reg_addr  <= 3'h4;
            reg_wdata <= 8'h80;
        end
        @(posedge clk) begin
            pll_tick <= 1'b0;
            reg_wr   <= 1'b0;
        end
        #1;
        chk("setwin", 12'h1, 12'(conv_trig[3]));
        chk_state(3, 1'b1, 1'b1, 1'b1);
        wr(3'h4, 8'hf0);
        wr(3'h3, 8'h00);
        @(posedge clk) raw[3] <= 1'b0;
        // clock source: pll tick, then amplifier tick
        wr(3'h0, 8'h88);
        @(posedge clk) raw[0] <= 1'b1;
        wait_cyc(6);
        chk("pll0", 12'h0, 12'(outs[0]));
        @(posedge clk) pll_tick <= 1'b1;
        wait_cyc(6);
        chk("pll1", 12'h1, 12'(outs[0]));
        wr(3'h6, 8'h01);
        @(posedge clk) begin
            pll_tick <= 1'b0;
            raw[0]   <= 1'b0;
        end
        wait_cyc(6);
        chk("amp0", 12'h1, 12'(outs[0]));
        @(posedge clk) amp_tick <= 3'h1;
        wait_cyc(6);
        chk("amp1", 12'h0, 12'(outs[0]));
        complete_run();
    end
endmodule
`default_nettype wire
